// file: scp_host.sv
`default_nettype none
// ==========================================================
// host side of the serial link: frames, readback sampling, recovery
module scp_host (
  input wire logic clk,
  input wire logic uni,
  input wire logic sdio_drv,
  input wire logic sdio_oe,
  input wire logic serial_readback_out,
  output scp_pkg::scp_pins_t pins,
  output logic io_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;
  logic [7:0] rd;
  logic line;
  // level seen by the host; a released line shows the inverse of its last bit
  assign line = uni ? serial_readback_out : (sdio_oe ? sdio_drv : ~pins.sdio);
  initial begin
    pins = PIN_RST;
    io_reset = 1'b0;
    rd = 8'h00;
  end
  // one frame, sclk levels of 4 clk each; readback sampled just before the next fall
  task automatic xfer(input logic [15:0] frame, input int nbits, input logic sel);
    for (int i = 0; i < nbits; i++) begin
      repeat (4) @(posedge clk);
      if (i > 8) rd[16 - i] <= line;
      pins.cs_n <= ~sel;
      pins.sclk <= 1'b0;
      pins.sdio <= (frame[15] && i > 7) ? ~pins.sdio : frame[15 - i];
      repeat (4) @(posedge clk);
      pins.sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    if (nbits > 8) rd[16 - nbits] <= line;
    pins.sclk <= 1'b0;
    repeat (4) @(posedge clk);
    if (nbits == 16) pins.cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // recovery pulse after a broken frame
  task automatic recover();
    io_reset <= 1'b1;
    repeat (4) @(posedge clk);
    io_reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // scp_host
`default_nettype wire

// file: scp_pkg.sv
`default_nettype none
// ==========================================================
// shared constants and types of the serial control port
package scp_pkg;
  localparam int INSTR_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam int NUM_REGS = 4;
  localparam int ADDR_W = 2;
  localparam int RD_BIT = 7; // instruction bit that marks a readback
  localparam int SYNC_DIV = 4; // system clock / 4 commit clock
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] DIV_RISE = 2'h1; // divider value before sync clock rises
  localparam logic [DATA_BITS-1:0] REG_RST = 8'h00;
  localparam logic [2:0] PIN_RST = 3'h2; // cs_n idles high

  // serial pins as they arrive, bit order matters for the synchroniser
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
  } scp_pins_t;

  typedef enum logic [1:0] {ST_INSTR, ST_WRITE, ST_READ, ST_DONE} scp_state_t;
endpackage : scp_pkg
`default_nettype wire

// file: scp_port.sv
// What this block does
// - commit pin high copies all staging buffers into the active registers
// - commit pin is input, or output when commits are generated internally
// - data line is bidirectional by default, input only in unidirectional mode
// - readback pin drives only in unidirectional mode, idle otherwise
// - write bits sampled on serial clock rise, readback bits driven on fall
// - select low enables the port; select high ignores the data pins
// - recovery input high restores the port; held low when unused
// - keying input pin controls output keying when enabled, else held high
// - output clock at system clock over four times the commit input
// - global reset clears all storage but the keying gate and the synchronised cs_n, both set high, and returns registers to defaults
`default_nettype none
module scp_port (
  input wire logic clk,
  input wire logic srst,
  input wire scp_pkg::scp_pins_t pins,
  input wire logic io_reset,
  input wire logic uni_mode,
  input wire logic commit_internal,
  input wire logic keying_en,
  input wire logic output_keying_ctl,
  input wire logic io_update_pin,
  output logic io_update_drv,
  output logic io_update_oe,
  output logic sdio_drv,
  output logic sdio_oe,
  output logic serial_readback_out,
  output logic serial_readback_oe,
  output logic sync_clk,
  output logic keying_gate,
  output logic [scp_pkg::NUM_REGS-1:0][scp_pkg::DATA_BITS-1:0] active_regs
);
  import scp_pkg::*;

  scp_pins_t pins_s;
  logic io_rst_s, upd_s, keying_s;
  logic sclk_d_ff, rise, fall, abort, tick, commit;
  scp_state_t state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [DATA_BITS-1:0] sh_ff, nxt_sh, rd_sh_ff, nxt_rd_sh;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic out_bit_ff, nxt_out_bit, drive_ff, nxt_drive;
  logic [NUM_REGS-1:0][DATA_BITS-1:0] stage_ff, nxt_stage, act_ff, nxt_act;
  logic pend_ff, nxt_pend, upd_out_ff, nxt_upd_out;
  logic [1:0] div_ff, nxt_div;
  logic gate_ff, nxt_gate;

  // ==========================================================
  // pin synchronisers
  scp_sync #(.W(3), .RST(PIN_RST)) u_pins (
    .clk(clk), .srst(srst), .d(pins), .q(pins_s)
  );
  scp_sync #(.W(3), .RST(3'h0)) u_ctl (
    .clk(clk), .srst(srst),
    .d({io_reset, io_update_pin, output_keying_ctl}),
    .q({io_rst_s, upd_s, keying_s})
  );

  // serial clock edges seen only while selected
  assign rise = pins_s.sclk & ~sclk_d_ff & ~pins_s.cs_n;
  assign fall = ~pins_s.sclk & sclk_d_ff & ~pins_s.cs_n;
  assign abort = io_rst_s | pins_s.cs_n;
  assign tick = (div_ff == DIV_RISE);
  assign commit = tick & (commit_internal ? pend_ff : upd_s);

  // shift one serial bit in at the bottom, msb leaves first
  function automatic logic [DATA_BITS-1:0] shift_in(input logic [DATA_BITS-1:0] v,
    input logic b);
    return {v[DATA_BITS-2:0], b};
  endfunction

  // ==========================================================
  // serial engine, commit timing and keying
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rd_sh = rd_sh_ff;
    nxt_addr = addr_ff;
    nxt_out_bit = out_bit_ff;
    nxt_drive = drive_ff;
    nxt_stage = stage_ff;
    nxt_act = act_ff;
    nxt_pend = pend_ff;
    nxt_upd_out = upd_out_ff;
    nxt_div = div_ff + 2'h1;
    nxt_gate = keying_en ? keying_s : 1'b1;
    // commit clock: copy at sync clock rise, pulse the pin when internal
    if (tick) begin
      nxt_upd_out = commit_internal & pend_ff;
      if (commit_internal) begin
        nxt_pend = 1'b0;
      end
    end
    if (commit) begin
      nxt_act = stage_ff;
    end
    if (abort) begin
      // drop partial bits and wait for a new instruction
      nxt_state = ST_INSTR;
      nxt_cnt = 3'h0;
      nxt_sh = '0;
      nxt_drive = 1'b0;
    end else begin
      case (state_ff)
        ST_INSTR: begin
          if (rise) begin
            nxt_sh = shift_in(sh_ff, pins_s.sdio);
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == BIT_LAST) begin
              nxt_addr = pins_s.sdio ? {sh_ff[0], 1'b1} : {sh_ff[0], 1'b0};
              nxt_rd_sh = act_ff[{sh_ff[0], pins_s.sdio}];
              nxt_state = sh_ff[RD_BIT-1] ? ST_READ : ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (rise) begin
            nxt_sh = shift_in(sh_ff, pins_s.sdio);
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == BIT_LAST) begin
              nxt_stage[addr_ff] = shift_in(sh_ff, pins_s.sdio);
              nxt_state = ST_DONE;
            end
          end
        end
        ST_READ: begin
          if (fall) begin
            nxt_out_bit = rd_sh_ff[DATA_BITS-1];
            nxt_rd_sh = shift_in(rd_sh_ff, 1'b0);
            nxt_drive = 1'b1;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == BIT_LAST) begin
              nxt_state = ST_DONE;
            end
          end
        end
        default: begin
          nxt_state = ST_DONE;
        end
      endcase
    end
    // a finished write arms the internal commit; set wins over clear
    if (!abort && state_ff == ST_WRITE && rise && cnt_ff == BIT_LAST) begin
      nxt_pend = 1'b1;
    end
  end

  // global reset clears every storage element but the keying gate, which it sets high
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_INSTR;
      cnt_ff <= 3'h0;
      sh_ff <= REG_RST;
      rd_sh_ff <= REG_RST;
      addr_ff <= '0;
      out_bit_ff <= 1'b0;
      drive_ff <= 1'b0;
      stage_ff <= '0;
      act_ff <= '0;
      pend_ff <= 1'b0;
      upd_out_ff <= 1'b0;
      div_ff <= 2'h0;
      gate_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rd_sh_ff <= nxt_rd_sh;
      addr_ff <= nxt_addr;
      out_bit_ff <= nxt_out_bit;
      drive_ff <= nxt_drive;
      stage_ff <= nxt_stage;
      act_ff <= nxt_act;
      pend_ff <= nxt_pend;
      upd_out_ff <= nxt_upd_out;
      div_ff <= nxt_div;
      gate_ff <= nxt_gate;
      sclk_d_ff <= pins_s.sclk;
    end
  end

  // ==========================================================
  // pin drivers
  assign sdio_drv = out_bit_ff;
  assign sdio_oe = drive_ff & ~uni_mode;
  assign serial_readback_out = out_bit_ff & uni_mode;
  assign serial_readback_oe = drive_ff & uni_mode;
  assign io_update_drv = upd_out_ff;
  assign io_update_oe = commit_internal;
  assign sync_clk = div_ff[1];
  assign keying_gate = gate_ff;
  assign active_regs = act_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_select_idle: assert property (pins_s.cs_n |=> state_ff == ST_INSTR && cnt_ff == 3'h0)
    else $error("port not idle while deselected");
  a_recover_abort: assert property (io_rst_s |=> state_ff == ST_INSTR && !drive_ff)
    else $error("recovery did not abort transfer");
  a_write_on_rise: assert property ((state_ff != ST_READ && !abort && !rise)
    |=> $stable(sh_ff))
    else $error("write shift without rising edge");
  a_read_on_fall: assert property ($changed(out_bit_ff) |-> $past(fall))
    else $error("readback bit changed off a falling edge");
  a_bidir_no_readback: assert property (!uni_mode |-> !serial_readback_oe)
    else $error("readback pin driven in bidirectional mode");
  a_uni_sdio_in: assert property (uni_mode |-> !sdio_oe)
    else $error("data line driven in unidirectional mode");
  a_drive_in_read: assert property ((sdio_oe || serial_readback_oe)
    |-> (state_ff == ST_READ || state_ff == ST_DONE))
    else $error("readback pins driven outside a read");
  a_commit_out_dir: assert property (io_update_drv |-> $past(commit_internal))
    else $error("commit pin pulsed while external");
  a_commit_copy: assert property (commit |=> act_ff == $past(stage_ff))
    else $error("commit did not copy staging buffers");
  a_sync_quarter: assert property ($rose(sync_clk) |-> ##4 $rose(sync_clk))
    else $error("sync clock not a quarter of clk");
  a_keying_pass: assert property (keying_en |=> keying_gate == $past(keying_s))
    else $error("keying pin not passed through");
  a_reset_clear: assert property (disable iff (1'b0) srst |=> act_ff == '0 && !drive_ff)
    else $error("reset did not clear registers");

  c_write_done: cover property (state_ff == ST_WRITE ##1 state_ff == ST_DONE);
  c_read_done: cover property (state_ff == ST_READ ##1 state_ff == ST_DONE);
  c_internal_commit: cover property (commit && commit_internal);
  c_recover_mid: cover property (io_rst_s && state_ff == ST_WRITE);
endmodule // scp_port
`default_nettype wire

// file: scp_sync.sv
`default_nettype none
// ==========================================================
// two flip-flop synchroniser for pins from outside the clock domain
module scp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= RST;
      q_ff <= RST;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // scp_sync
`default_nettype wire

// file: serial_control_port_pins_test.sv
`default_nettype none
// ==========================================================
// self-checking bench of the serial control port
module serial_control_port_pins_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;
  logic clk = 1'b0, srst = 1'b1, uni_mode = 1'b0, commit_internal = 1'b1, prev;
  logic keying_en = 1'b0, output_keying_ctl = 1'b1, io_update_pin = 1'b0, io_reset;
  logic io_update_drv, io_update_oe, sdio_drv, sdio_oe, serial_readback_out, serial_readback_oe;
  logic sync_clk, keying_gate, seen_bi, seen_uni, seen_upd = 1'b0;
  logic [NUM_REGS-1:0][DATA_BITS-1:0] active_regs;
  scp_pins_t hp, dp;
  int n_mismatch = 0, n_compared = 0, rises = 0;
  // rows: uni mode, register index, data byte
  logic [10:0] rows [4] = '{11'h0A5, 11'h15A, 11'h6FF, 11'h701};
  always #12.5 clk = ~clk;
  // level of the shared data line
  assign dp = '{sclk: hp.sclk, cs_n: hp.cs_n, sdio: sdio_oe ? sdio_drv : hp.sdio};
  // note which pins drove
  always @(posedge clk) begin
    if (sdio_oe) seen_bi <= 1'b1;
    if (serial_readback_oe) seen_uni <= 1'b1;
    if (io_update_drv) seen_upd <= 1'b1;
  end
  scp_port scp_port_inst (.clk, .srst, .pins(dp), .io_reset, .uni_mode,
    .commit_internal, .keying_en, .output_keying_ctl, .io_update_pin, .io_update_drv,
    .io_update_oe, .sdio_drv, .sdio_oe, .serial_readback_out, .serial_readback_oe,
    .sync_clk, .keying_gate, .active_regs);
  scp_host scp_host_inst (.clk, .uni(uni_mode), .sdio_drv, .sdio_oe, .serial_readback_out,
    .pins(hp), .io_reset);
  // compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check("regs", 8'h00, active_regs[0] | active_regs[3]);
    check("keying", 8'h01, {7'h00, keying_gate});
    foreach (rows[k]) begin
      {seen_bi, seen_uni} <= 2'h0;
      uni_mode <= rows[k][10];
      scp_host_inst.xfer({6'h00, rows[k][9:0]}, 16, 1'b1);
      check("reg", rows[k][7:0], active_regs[rows[k][9:8]]);
      scp_host_inst.xfer({6'h20, rows[k][9:8], 8'h00}, 16, 1'b1);
      check("readback", rows[k][7:0], scp_host_inst.rd);
      check("oe", {6'h00, rows[k][10], ~rows[k][10]}, {6'h00, seen_uni, seen_bi});
    end
    check("commit out", 8'h03, {6'h00, seen_upd, io_update_oe});
    scp_host_inst.xfer(16'h0033, 16, 1'b0);
    check("deselected", 8'hA5, active_regs[0]);
    scp_host_inst.xfer(16'h01C3, 5, 1'b1);
    scp_host_inst.recover();
    scp_host_inst.xfer(16'h01C3, 16, 1'b1);
    check("after abort", 8'hC3, active_regs[1]);
    commit_internal <= 1'b0;
    scp_host_inst.xfer(16'h023C, 16, 1'b1);
    check("held", 8'hFF, active_regs[2]);
    check("commit in", 8'h00, {7'h00, io_update_oe});
    io_update_pin <= 1'b1;
    repeat (8) @(posedge clk);
    io_update_pin <= 1'b0;
    repeat (4) @(posedge clk);
    check("commit", 8'h3C, active_regs[2]);
    repeat (40) begin
      prev = sync_clk;
      @(posedge clk);
      if (sync_clk === 1'b1 && prev === 1'b0) rises++;
    end
    check("sync rises", 8'h0A, rises[7:0]);
    keying_en <= 1'b1;
    output_keying_ctl <= 1'b0;
    repeat (6) @(posedge clk);
    check("keying low", 8'h00, {7'h00, keying_gate});
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("reset regs", 8'h00, active_regs[2]);
    commit_internal <= 1'b1;
    scp_host_inst.xfer(16'h0155, 16, 1'b1);
    check("after reset", 8'h55, active_regs[1]);
    end_sim();
  end
  // cut a hang short; the tests take some 1900 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule // serial_control_port_pins_test
`default_nettype wire
